// ### rtl/boot_remap_memory_map.sv
// System address decoder with boot remap, flash header check and the
// sleep/off bookkeeping of mode and remap.
// Assumes one clock mclk, processor requests on the same clock, wake pins
// asynchronous, and a flash read port that answers with a one-cycle ack.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - Boot ROM sits at zero while booting
// - Mirror mode aliases one SRAM bank at zero
// - Flash mode aliases flash at zero
// - Remap 0 boot ROM, 1 SRAM, 2 flash
// - Reserved ROM 8 KB, boot ROM 120 KB
// - First two 32 KB SRAM banks contiguous
// - Banks of 64, 8 and 2 KB
// - Flash at 1100_0000 and alias 6000_0000
// - Flash 256/512 KB, two-wire reads
// - Per-bank retention; banks take code and data
// - Valid header runs program, else programming mode
// - Wait instruction gates core clock until wake
// - Sleep and off have their own wake sources
// - Save mode, remap and vector before sleep
// - Wake restarts in boot mode, state kept
// - Power switches follow normal, sleep, off
module boot_remap_memory_map #(
  parameter logic [31:0] PRODUCT_MODE_VALID = 32'h5A5A_0001 // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Processor access in, decoded access out
  input wire memmap_pkg::cpu_req_t cpu_req,
  output memmap_pkg::mem_req_t mem_req,
  // Register bus
  input wire memmap_pkg::wb_req_t wb_req,
  output memmap_pkg::wb_rsp_t wb_rsp,
  // Flash header read port
  output logic flash_rd_req,
  output logic [memmap_pkg::OFF_W-1:0] flash_rd_addr,
  input wire logic [memmap_pkg::DATA_W-1:0] flash_rd_data,
  input wire logic flash_rd_ack,
  output logic flash_dual_wire,
  // Core clock gating
  input wire logic cpu_wait,
  input wire logic [memmap_pkg::IRQ_W-1:0] irq_event,
  output logic core_clk_en,
  // Wake pins: io, rtc, reset pin, undervoltage
  input wire logic [memmap_pkg::PIN_W-1:0] wake_pin,
  // Power and boot state
  output memmap_pkg::power_sw_t power_sw,
  output logic [memmap_pkg::NUM_BANK-1:0] sram_on,
  output logic [memmap_pkg::NUM_BANK-1:0] sram_retain,
  output logic run_normal,
  output logic prog_mode
);
  import memmap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  remap_t remap;                         // Region at address zero
  logic flash_512;                       // Flash is 512 KB when set
  logic [NUM_BANK-1:0] retention;        // Per-bank retention enables
  logic [KEEP_W-1:0] sleep_keep;         // Optional blocks kept in sleep
  logic [IRQ_W-1:0] wake_sel;            // Events that restart the core
  remap_t saved_remap;                   // Remap captured before sleep
  logic saved_flash_mode;                // Flash mode captured before sleep
  logic [ADDR_W-1:0] saved_vector;       // Vector location for the return
  power_state_t pwr_state;               // Normal, sleep or off
  logic core_gated;                      // Core clock stopped
  logic woke;                            // Set on a wake from sleep or off
  hdr_state_t hdr_state;                 // Header check progress
  logic hdr_start;                       // Request a fresh header check
  logic [HDR_IDX_W-1:0] hdr_idx;         // Header word being read
  logic [DATA_W-1:0] hdr_mode;           // Chip mode word
  logic [DATA_W-1:0] hdr_base;           // Code base address
  logic [DATA_W-1:0] hdr_len;            // Code length
  logic [DATA_W-1:0] hdr_boot;           // Mirror or flash selection
  logic [PIN_W-1:0] pin_meta;            // First synchroniser stage
  logic [PIN_W-1:0] pin_sync;            // Second stage, safe to read
  logic wake_io, wake_rtc, wake_rst, wake_uvlo;
  logic sleep_exit, off_exit;
  logic wb_access, wb_write, reg_hit;
  logic [REG_ADR_W-1:0] reg_adr;
  logic [DATA_W-1:0] next_rdata;
  logic [ADDR_W-1:0] remap_base, eff_addr;
  logic [NUM_REGION-1:0] rgn_hit;
  logic [OFF_W-1:0] rgn_off [NUM_REGION];
  mem_req_t next_mem;
  logic hdr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Wake pins cross in through two flip-flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= wake_pin;
      pin_sync <= pin_meta;
    end
  end

  assign wake_io = pin_sync[0];
  assign wake_rtc = pin_sync[1];
  assign wake_rst = pin_sync[2];
  assign wake_uvlo = pin_sync[3];
  // The rtc cannot end the off state; everything is powered down there
  assign sleep_exit = wake_io | wake_rtc | wake_rst | wake_uvlo;
  assign off_exit = wake_io | wake_rst | wake_uvlo;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  assign wb_access = wb_req.cyc && wb_req.stb && !wb_rsp.ack && !wb_rsp.err;
  assign wb_write = wb_access && wb_req.we && reg_hit;
  assign reg_adr = wb_req.adr[REG_ADR_W-1:0];

  // Read mux; also tells whether the offset is mapped
  always_comb begin
    reg_hit = 1'b1;
    next_rdata = '0;
    unique case (reg_adr)
      REG_REMAP_CTRL: begin
        next_rdata[FLD_REMAP_LSB +: 2] = remap;
        next_rdata[FLD_FLASH_512] = flash_512;
        next_rdata[FLD_DUAL_WIRE] = flash_dual_wire;
      end
      REG_RETENTION: next_rdata[NUM_BANK-1:0] = retention;
      REG_POWER_CTRL: next_rdata[FLD_KEEP_LSB +: KEEP_W] = sleep_keep;
      REG_WAKE_SEL: next_rdata[IRQ_W-1:0] = wake_sel;
      REG_SAVED_MODE: begin
        next_rdata[FLD_REMAP_LSB +: 2] = saved_remap;
        next_rdata[FLD_FLASH_512] = saved_flash_mode;
      end
      REG_SAVED_VECTOR: next_rdata = saved_vector;
      REG_STATUS: begin
        next_rdata[1:0] = pwr_state;
        next_rdata[2] = (hdr_state == HDR_DONE);
        next_rdata[3] = run_normal;
        next_rdata[4] = prog_mode;
        next_rdata[5] = woke;
        next_rdata[6] = core_gated;
        next_rdata[9:8] = hdr_boot[1:0];
      end
      REG_HDR_BASE: next_rdata = hdr_base;
      REG_HDR_LEN: next_rdata = hdr_len;
      // Anything else is not a register
      default: reg_hit = 1'b0;
    endcase
  end

  // One-cycle answer; ack or err drops in the following cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= wb_access && reg_hit;
      wb_rsp.err <= wb_access && !reg_hit;
      wb_rsp.dat <= (wb_access && reg_hit && !wb_req.we) ? next_rdata : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remap and flash configuration
  // A wake forces boot ROM back to zero; software restores the saved choice
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      remap <= REMAP_BOOT_ROM;
      flash_512 <= 1'b1;
      flash_dual_wire <= 1'b1;
    end else if (pwr_state != PWR_NORMAL) begin
      if ((pwr_state == PWR_SLEEP && sleep_exit) || (pwr_state == PWR_OFF && off_exit)) begin
        remap <= REMAP_BOOT_ROM;
      end
    end else if (wb_write && reg_adr == REG_REMAP_CTRL && wb_req.sel[0]) begin
      // Code 3 names no region and leaves the field unchanged
      if (wb_req.dat[FLD_REMAP_LSB +: 2] != 2'h3) begin
        remap <= remap_t'(wb_req.dat[FLD_REMAP_LSB +: 2]);
      end
      flash_512 <= wb_req.dat[FLD_FLASH_512];
      flash_dual_wire <= wb_req.dat[FLD_DUAL_WIRE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retention, wake selection and saved vector registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      retention <= RETENTION_RST;
      sleep_keep <= '0;
      wake_sel <= WAKE_SEL_RST;
      saved_vector <= VECTOR_RST;
    end else if (wb_write && wb_req.sel[0]) begin
      if (reg_adr == REG_RETENTION) begin
        retention <= wb_req.dat[NUM_BANK-1:0];
      end
      if (reg_adr == REG_POWER_CTRL) begin
        sleep_keep <= wb_req.dat[FLD_KEEP_LSB +: KEEP_W];
      end
      if (reg_adr == REG_WAKE_SEL) begin
        wake_sel <= wb_req.dat[IRQ_W-1:0];
      end
      if (reg_adr == REG_SAVED_VECTOR) begin
        saved_vector <= wb_req.dat;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state: entry by a write, exit by the state's own wake sources
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state <= PWR_NORMAL;
      saved_remap <= REMAP_BOOT_ROM;
      saved_flash_mode <= 1'b0;
    end else begin
      unique case (pwr_state)
        PWR_NORMAL: begin
          if (wb_write && reg_adr == REG_POWER_CTRL && wb_req.sel[0]) begin
            if (wb_req.dat[FLD_PWR_REQ_LSB +: 2] == PWR_REQ_SLEEP) begin
              pwr_state <= PWR_SLEEP;
            end else if (wb_req.dat[FLD_PWR_REQ_LSB +: 2] == PWR_REQ_OFF) begin
              pwr_state <= PWR_OFF;
            end
            // Capture the mode so the boot code can rebuild it after wake
            saved_remap <= remap;
            saved_flash_mode <= (remap == REMAP_FLASH);
          end
        end
        PWR_SLEEP: begin
          if (sleep_exit) begin
            pwr_state <= PWR_NORMAL;
          end
        end
        PWR_OFF: begin
          if (off_exit) begin
            pwr_state <= PWR_NORMAL;
          end
        end
        default: pwr_state <= PWR_NORMAL;
      endcase
    end
  end

  // Wake flag: set on exit, cleared when software rewrites the remap;
  // the set wins so a wake in the clearing cycle still shows
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      woke <= 1'b0;
    end else if (hdr_start) begin
      woke <= 1'b1;
    end else if (wb_write && reg_adr == REG_REMAP_CTRL) begin
      woke <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core clock gate; a selected event in the wait cycle keeps the core running
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      core_gated <= 1'b0;
    end else if (|(irq_event & wake_sel)) begin
      core_gated <= 1'b0;
    end else if (cpu_wait) begin
      core_gated <= 1'b1;
    end
  end

  assign core_clk_en = !core_gated && (pwr_state == PWR_NORMAL);

  ////////////////////////////////////////////////////////////////////////////
  // Power switches and SRAM supplies, registered from the power state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_sw <= '1;
      sram_on <= '1;
      sram_retain <= '0;
    end else begin
      unique case (pwr_state)
        PWR_NORMAL: begin
          power_sw <= '1;
          sram_on <= '1;
          sram_retain <= '0;
        end
        PWR_SLEEP: begin
          // Only the low-current regulator and chosen slow blocks stay up
          power_sw <= '0;
          power_sw.low_current_regulator <= 1'b1;
          power_sw.slow_rc_osc <= sleep_keep[0];
          power_sw.slow_crystal_osc <= sleep_keep[1];
          power_sw.comparator <= sleep_keep[2];
          power_sw.rtc <= sleep_keep[3];
          sram_on <= '0;
          sram_retain <= retention;
        end
        PWR_OFF: begin
          power_sw <= '0;
          sram_on <= '0;
          sram_retain <= '0;
        end
        default: power_sw <= '1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash header check after reset and after every wake
  assign hdr_start = (pwr_state == PWR_SLEEP) ? sleep_exit : (pwr_state == PWR_OFF) && off_exit;
  // Layout of the header is the flash image's business; only the checks are ours
  assign hdr_ok = (hdr_mode == PRODUCT_MODE_VALID) && (hdr_len != '0)
    && hdr_len <= (flash_512 ? REGION_SIZE[RGN_FLASH] : {13'h0000, FLASH_SMALL_SIZE});

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_state <= HDR_IDLE;
      hdr_idx <= '0;
      flash_rd_req <= 1'b0;
      flash_rd_addr <= HDR_MODE_OFF;
      hdr_mode <= '0;
      hdr_base <= '0;
      hdr_len <= '0;
      hdr_boot <= '0;
      run_normal <= 1'b0;
      prog_mode <= 1'b0;
    end else if (hdr_start) begin
      hdr_state <= HDR_IDLE;
      run_normal <= 1'b0;
      prog_mode <= 1'b0;
    end else begin
      unique case (hdr_state)
        HDR_IDLE: begin
          hdr_idx <= '0;
          flash_rd_addr <= HDR_MODE_OFF;
          flash_rd_req <= 1'b1;
          hdr_state <= HDR_READ;
        end
        HDR_READ: begin
          if (flash_rd_ack) begin
            unique case (hdr_idx)
              '0: hdr_mode <= flash_rd_data;
              HDR_IDX_BASE: hdr_base <= flash_rd_data;
              HDR_IDX_LEN: hdr_len <= flash_rd_data;
              default: hdr_boot <= flash_rd_data;
            endcase
            if (hdr_idx == HDR_IDX_LAST) begin
              flash_rd_req <= 1'b0;
              hdr_state <= HDR_DONE;
            end else begin
              hdr_idx <= hdr_idx + 1'b1;
              flash_rd_addr <= flash_rd_addr + HDR_WORD_STEP;
            end
          end
        end
        HDR_DONE: begin
          run_normal <= hdr_ok;
          prog_mode <= !hdr_ok;
        end
        default: hdr_state <= HDR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; the low window is shifted onto the remapped region
  always_comb begin
    unique case (remap)
      REMAP_SRAM: remap_base = REGION_BASE[RGN_SRAM_A + 2];
      REMAP_FLASH: remap_base = REGION_BASE[RGN_FLASH];
      default: remap_base = REGION_BASE[RGN_BOOT_ROM];
    endcase
    // Exactly one region answers at zero, whichever remap is chosen
    eff_addr = cpu_req.addr < REMAP_WINDOW ? remap_base + cpu_req.addr : cpu_req.addr;
  end

  // One comparator per window: ROMs, five banks, flash and its alias
  for (genvar r = 0; r < NUM_REGION; r++) begin : g_rgn
    region_decoder #(
      .BASE(REGION_BASE[r]),
      .SIZE(REGION_SIZE[r])
    ) region_decoder_inst (
      .addr(eff_addr),
      .hit(rgn_hit[r]),
      .offset(rgn_off[r])
    );
  end

  // Select, offset and error; banks take fetches and data alike
  always_comb begin
    next_mem = '0;
    next_mem.valid = cpu_req.valid;
    next_mem.we = cpu_req.we;
    for (int r = 0; r < NUM_TARGET; r++) begin
      if (rgn_hit[r]) begin
        next_mem.sel[r] = 1'b1;
        next_mem.offset = rgn_off[r];
      end
    end
    if (rgn_hit[RGN_FLASH_ALIAS]) begin
      next_mem.sel[RGN_FLASH] = 1'b1;
      next_mem.offset = rgn_off[RGN_FLASH_ALIAS];
    end
    // The upper half of a small flash is not there
    if (next_mem.sel[RGN_FLASH] && !flash_512 && next_mem.offset >= FLASH_SMALL_SIZE) begin
      next_mem.sel = '0;
    end
    if (cpu_req.valid && next_mem.sel == '0) begin
      next_mem.err = 1'b1;
    end
    if (!cpu_req.valid) begin
      next_mem.sel = '0;
    end
  end

  // Registered decode result, one cycle after the request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= '0;
    end else begin
      mem_req <= next_mem;
    end
  end

endmodule

// ### rtl/memmap_pkg.sv
// Constants, types and register layout of the boot remap memory map.
// Assumes a 32-bit processor address bus and a 32-bit classic Wishbone bus.
package memmap_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  localparam int OFF_W = 19;       // Largest region is 512 KB
  localparam int NUM_REGION = 9;   // Flash alias counts as its own window
  localparam int NUM_TARGET = 8;
  localparam int NUM_BANK = 5;
  localparam int IRQ_W = 8;
  localparam int PIN_W = 4;        // io wake, rtc wake, reset pin, undervoltage
  localparam int HDR_WORDS = 4;
  localparam int HDR_IDX_W = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Region windows, index order equals target order; alias last
  localparam int RGN_RESERVED_ROM = 0;
  localparam int RGN_BOOT_ROM = 1;
  localparam int RGN_SRAM_A = 2;
  localparam int RGN_SRAM_E = 6;
  localparam int RGN_FLASH = 7;
  localparam int RGN_FLASH_ALIAS = 8;
  localparam logic [ADDR_W-1:0] REGION_BASE [NUM_REGION] = '{
    32'h1000_0000, 32'h1000_2000, 32'h1FFF_0000, 32'h1FFF_8000, 32'h2000_0000,
    32'h2001_0000, 32'h2001_2000, 32'h1100_0000, 32'h6000_0000};
  localparam logic [ADDR_W-1:0] REGION_SIZE [NUM_REGION] = '{
    32'h0000_2000, 32'h0001_E000, 32'h0000_8000, 32'h0000_8000, 32'h0001_0000,
    32'h0000_2000, 32'h0000_0800, 32'h0008_0000, 32'h0008_0000};
  localparam logic [ADDR_W-1:0] REMAP_WINDOW = 32'h0008_0000;
  localparam logic [OFF_W-1:0] FLASH_SMALL_SIZE = 19'h4_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses) and fields
  localparam int REG_ADR_W = 8;
  localparam logic [REG_ADR_W-1:0] REG_REMAP_CTRL = 8'h00;
  localparam logic [REG_ADR_W-1:0] REG_RETENTION = 8'h04;
  localparam logic [REG_ADR_W-1:0] REG_POWER_CTRL = 8'h08;
  localparam logic [REG_ADR_W-1:0] REG_WAKE_SEL = 8'h0C;
  localparam logic [REG_ADR_W-1:0] REG_SAVED_MODE = 8'h10;
  localparam logic [REG_ADR_W-1:0] REG_SAVED_VECTOR = 8'h14;
  localparam logic [REG_ADR_W-1:0] REG_STATUS = 8'h18;
  localparam logic [REG_ADR_W-1:0] REG_HDR_BASE = 8'h1C;
  localparam logic [REG_ADR_W-1:0] REG_HDR_LEN = 8'h20;
  localparam int FLD_REMAP_LSB = 0;
  localparam int FLD_FLASH_512 = 2;
  localparam int FLD_DUAL_WIRE = 3;
  localparam int FLD_PWR_REQ_LSB = 0;
  localparam int FLD_KEEP_LSB = 4;
  localparam int KEEP_W = 4;       // slow rc, slow crystal, comparator, rtc
  localparam logic [1:0] PWR_REQ_SLEEP = 2'h1;
  localparam logic [1:0] PWR_REQ_OFF = 2'h2;

  // Reset values
  localparam logic [NUM_BANK-1:0] RETENTION_RST = 5'h1F;
  localparam logic [IRQ_W-1:0] WAKE_SEL_RST = 8'hFF;
  localparam logic [ADDR_W-1:0] VECTOR_RST = 32'h0000_0000;

  // Flash header layout, byte offsets within the flash
  localparam logic [OFF_W-1:0] HDR_MODE_OFF = 19'h0_0000;
  localparam logic [OFF_W-1:0] HDR_WORD_STEP = 19'h0_0004;
  localparam logic [HDR_IDX_W-1:0] HDR_IDX_BASE = 2'h1;
  localparam logic [HDR_IDX_W-1:0] HDR_IDX_LEN = 2'h2;
  localparam logic [HDR_IDX_W-1:0] HDR_IDX_LAST = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Enumerations; remap order gives codes 0, 1, 2
  typedef enum logic [1:0] {REMAP_BOOT_ROM, REMAP_SRAM, REMAP_FLASH} remap_t;
  typedef enum logic [1:0] {PWR_NORMAL, PWR_SLEEP, PWR_OFF} power_state_t;
  typedef enum logic [1:0] {HDR_IDLE, HDR_READ, HDR_DONE} hdr_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic valid;
    logic we;
    logic [ADDR_W-1:0] addr;
  } cpu_req_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic err;
    logic [NUM_TARGET-1:0] sel;
    logic [OFF_W-1:0] offset;
  } mem_req_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DATA_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [DATA_W-1:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic fast_rc_osc;
    logic slow_rc_osc;
    logic slow_crystal_osc;
    logic bandgap;
    logic low_current_regulator;
    logic dcdc;
    logic core_regulator;
    logic charge_pump;
    logic comparator;
    logic rtc;
  } power_sw_t;

endpackage

// ### rtl/region_decoder.sv
// One address window comparator: hit and offset for a base and a size.
// Assumes base plus size does not wrap past the top of the address space.
`timescale 1ns/1ps
module region_decoder #(
  parameter logic [31:0] BASE = 32'h0000_0000,
  parameter logic [31:0] SIZE = 32'h0000_1000
) (
  // Address in
  input wire logic [memmap_pkg::ADDR_W-1:0] addr,
  // Match out
  output logic hit,
  output logic [memmap_pkg::OFF_W-1:0] offset
);
  import memmap_pkg::*;

  logic [ADDR_W-1:0] diff; // Distance from the window base

  // Plain range test; window sizes need not be powers of two
  always_comb begin
    diff = addr - BASE;
    hit = (addr >= BASE) && (diff < SIZE);
    offset = diff[OFF_W-1:0];
  end

endmodule

// ### verification/boot_remap_memory_map_asserts.sv
// Checker of decode, header and clock-gate timing of the memory map.
// Assumes it is bound onto the top module; mclk is the only clock.
`timescale 1ns/1ps
module boot_remap_memory_map_asserts import memmap_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Watched ports
  input wire cpu_req_t cpu_req,
  input wire mem_req_t mem_req,
  input wire logic flash_rd_req,
  input wire logic flash_rd_ack,
  input wire logic cpu_wait,
  input wire logic [IRQ_W-1:0] irq_event,
  input wire logic core_clk_en,
  input wire logic run_normal,
  input wire logic prog_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Short views of the request
  wire logic v = cpu_req.valid;
  wire logic [31:0] a = cpu_req.addr;
  chk_res_rom: assert property (v && a[31:13] == 19'h0_8000 |=> mem_req.sel == 8'h01)
    else $error("reserved rom miss");
  chk_boot_rom: assert property (v && a >= 32'h1000_2000 && a <= 32'h1001_FFFF
    |=> mem_req.sel == 8'h02) else $error("boot rom miss");
  chk_sram_pair: assert property (v && a[31:16] == 16'h1FFF
    |=> mem_req.sel == ($past(a[15]) ? 8'h08 : 8'h04)) else $error("sram pair miss");
  chk_small_bank: assert property (v && a[31:11] == 21'h04_0024 |=> mem_req.sel == 8'h40)
    else $error("small bank miss");
  chk_flash_alias: assert property (v && a[31:18] == 14'h1800
    |=> mem_req.sel == 8'h80 && mem_req.offset == $past(a[18:0])) else $error("alias miss");
  chk_hole_err: assert property (v && a[31:28] == 4'h7 |=> mem_req.err && ~|mem_req.sel)
    else $error("hole not refused");
  chk_gate_stop: assert property (cpu_wait && irq_event == 8'h00 |=> !core_clk_en)
    else $error("core clock not gated");
  chk_hdr_excl: assert property (run_normal |-> !prog_mode)
    else $error("both boot results");
  chk_hdr_hold: assert property (flash_rd_req && !flash_rd_ack |=> flash_rd_req)
    else $error("header read dropped");
endmodule
bind boot_remap_memory_map boot_remap_memory_map_asserts boot_remap_memory_map_asserts_inst (.*);

// ### verification/boot_remap_memory_map_tb_top.sv
// Bench of the memory map: remap, decode, gating, sleep, off, header.
// Assumes a one-cycle bus answer and the flash header model.
`timescale 1ns/1ps
module boot_remap_memory_map_tb_top;
  import memmap_pkg::*;
  logic mclk, rst_n, cpu_wait, good, e, flash_rd_ack, flash_rd_req;
  logic core_clk_en, run_normal, prog_mode, flash_dual_wire;
  logic [3:0] wake_pin, lat;
  logic [7:0] irq_event;
  logic [4:0] sram_on, sram_retain;
  logic [31:0] flash_rd_data, q, off;
  logic [18:0] flash_rd_addr;
  cpu_req_t cpu_req;
  mem_req_t mem_req;
  wb_req_t wb_req;
  wb_rsp_t wb_rsp;
  power_sw_t power_sw;
  int num_errors, check_count, n, r, i;
  logic [7:0] zero_sel [3] = '{8'h02, 8'h10, 8'h80};
  boot_remap_memory_map boot_remap_memory_map_inst (.*);
  flash_hdr_model flash_hdr_model_inst (.*);
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic guard();
    if (i >= 300) begin
      num_errors++;
      end_of_test();
    end
  endtask
  // One classic cycle; waits for ack or err under a bound
  task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {24'h0, ad}, sel: 4'hF, dat: d};
    for (i = 0; i < 300; i++) begin
      @(posedge mclk);
      if (wb_rsp.ack || wb_rsp.err) break;
    end
    guard();
    q = wb_rsp.dat;
    e = wb_rsp.err;
    wb_req <= '0;
  endtask
  // One processor access; offset ignored on a refused access
  task automatic cpu(input logic [31:0] a, input logic [7:0] es, input logic [18:0] eo,
                     input logic ee);
    @(posedge mclk);
    cpu_req <= '{valid: 1'b1, we: 1'b0, addr: a};
    @(posedge mclk);
    cpu_req <= '0;
    @(negedge mclk);
    chk({mem_req.valid, mem_req.err, mem_req.sel, ee ? 19'h0 : mem_req.offset},
        {1'b1, ee, es, eo});
  endtask
  task automatic pulse(input logic [3:0] p);
    @(posedge mclk);
    wake_pin <= p;
    repeat (3) @(posedge mclk);
    wake_pin <= 4'h0;
  endtask
  // Header read starts, then ends; result settles one cycle later
  task automatic hdr_wait();
    for (i = 0; i < 300 && !flash_rd_req; i++) @(posedge mclk);
    while (i < 300 && flash_rd_req) begin
      @(posedge mclk);
      i++;
    end
    guard();
    repeat (3) @(posedge mclk);
  endtask
  initial begin
    repeat (50000) @(posedge mclk);
    num_errors++;
    end_of_test();
  end
  initial begin
    {rst_n, cpu_wait, good, wake_pin, irq_event} = '0;
    good = 1'b1;
    cpu_req = '0;
    wb_req = '0;
    void'($urandom(76104));
    lat = 4'($urandom % 4);
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    hdr_wait();
    chk({run_normal, prog_mode, flash_dual_wire}, 3'b101);
    cpu(32'h0000_0010, 8'h02, 19'h10, 1'b0);
    wb(1'b1, REG_RETENTION, 32'h0A);
    wb(1'b0, REG_RETENTION, 32'h0);
    chk(q[4:0], 5'h0A);
    for (n = 0; n < 3; n++) begin
      wb(1'b1, REG_REMAP_CTRL, 32'h0C | n);
      cpu(32'h0000_0010, zero_sel[n], 19'h10, 1'b0);
    end
    wb(1'b1, REG_REMAP_CTRL, 32'h0F);
    cpu(32'h0, 8'h80, 19'h0, 1'b0);
    wb(1'b0, 8'h40, 32'h0);
    chk(e, 1'b1);
    cpu(32'h7000_0000, 8'h00, 19'h0, 1'b1);
    wb(1'b1, REG_REMAP_CTRL, 32'h0A);
    cpu(32'h1104_0000, 8'h00, 19'h0, 1'b1);
    wb(1'b1, REG_REMAP_CTRL, 32'h0E);
    for (n = 0; n < 40; n++) begin
      r = $urandom % NUM_REGION;
      off = $urandom % REGION_SIZE[r];
      cpu(REGION_BASE[r] + off, 8'h01 << (r > 7 ? 7 : r), off[18:0], 1'b0);
    end
    @(posedge mclk);
    cpu_wait <= 1'b1;
    @(posedge mclk);
    cpu_wait <= 1'b0;
    irq_event <= 8'h01;
    @(negedge mclk);
    chk(core_clk_en, 1'b0);
    @(negedge mclk);
    chk(core_clk_en, 1'b1);
    wb(1'b1, REG_POWER_CTRL, 32'h81);
    @(negedge mclk);
    chk({power_sw.fast_rc_osc, power_sw.low_current_regulator, power_sw.dcdc,
         power_sw.rtc, sram_on, sram_retain}, {4'b0101, 10'h00A});
    pulse(4'h2);
    hdr_wait();
    cpu(32'h0000_0010, 8'h02, 19'h10, 1'b0);
    wb(1'b0, REG_SAVED_MODE, 32'h0);
    chk(q[1:0], 2'h2);
    wb(1'b1, REG_POWER_CTRL, 32'h2);
    pulse(4'h2);
    repeat (4) @(posedge mclk);
    chk(power_sw.fast_rc_osc, 1'b0);
    pulse(4'h1);
    hdr_wait();
    chk(power_sw.fast_rc_osc, 1'b1);
    rst_n <= 1'b0;
    good <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    hdr_wait();
    chk({run_normal, prog_mode}, 2'b01);
    end_of_test();
  end
endmodule

// ### verification/flash_hdr_model.sv
// Flash model answering header word reads after a chosen latency.
// Assumes the reader holds the request until each ack.
`timescale 1ns/1ps
module flash_hdr_model (
  // Clock, reset and read port
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic flash_rd_req,
  input wire logic [18:0] flash_rd_addr,
  // Bench controls: header good, answer latency
  input wire logic good,
  input wire logic [3:0] lat,
  output logic [31:0] flash_rd_data,
  output logic flash_rd_ack
);
  logic [3:0] wait_cnt; // Cycles since last answer
  // Data toggles outside ack so stale words never pass
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 4'h0;
      flash_rd_ack <= 1'b0;
      flash_rd_data <= 32'hFFFF_FFFF;
    end else if (flash_rd_req && !flash_rd_ack && wait_cnt >= lat) begin
      wait_cnt <= 4'h0;
      flash_rd_ack <= 1'b1;
      case (flash_rd_addr[3:2])
        2'h0: flash_rd_data <= good ? 32'h5A5A_0001 : 32'hA5A5_FFFE;
        2'h1: flash_rd_data <= 32'h1FFF_0000;
        2'h2: flash_rd_data <= 32'h0000_0100;
        default: flash_rd_data <= 32'h0000_0001;
      endcase
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      flash_rd_ack <= 1'b0;
      flash_rd_data <= ~flash_rd_data;
    end
  end
endmodule
